// ---- include/motion_cmd_pkg.sv ----
// How it works
// - enabled source with defined vector suspends program and jumps to its handler
// - accumulator, X register and flags are saved before handler entry
// - no nesting; other sources held off until the handler returns
// - return_from_irq restores saved context and resumes at interrupted address
// - global_param_write with bank 3 sets interrupt settings such as timer interval
// - interrupt taken only with own enable and global enable (number 255)
// - code 1 selects velocity mode, target velocity gets value, positive direction
// - code 2 selects velocity mode, target velocity gets value, negative direction
// - velocity operand is a signed 32-bit microsteps per second value
// - code 3 selects velocity mode and sets target velocity to zero
// - accepted rotate or stop commands reply with status 100
// - frame is address, instruction, type, bank, value msb first, checksum
// - fixed interrupt numbers: timers 0 to 2, input change 39
package motion_cmd_pkg;
  localparam int FRAME_LEN = 9;
  localparam logic [7:0] INSN_ROTATE_CW = 8'h01;
  localparam logic [7:0] INSN_ROTATE_CCW = 8'h02;
  localparam logic [7:0] INSN_SOFT_STOP = 8'h03;
  localparam logic [7:0] INSN_GLOBAL_PARAM = 8'h09;
  localparam logic [7:0] INSN_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] INSN_IRQ_DISABLE = 8'h1A;
  localparam logic [7:0] INSN_IRQ_VECTOR = 8'h25;
  localparam logic [7:0] INSN_RETURN_IRQ = 8'h26;
  localparam logic [7:0] IRQ_BANK = 8'h03;
  localparam logic [7:0] IRQ_GLOBAL = 8'hFF;
  localparam logic [7:0] IRQ_TIMER0 = 8'h00;
  localparam logic [7:0] IRQ_TIMER2 = 8'h02;
  localparam logic [7:0] IRQ_INPUT_CHANGE = 8'h27;
  localparam int NUM_SRC = 4;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] TARGET_VEL_PARAM = 8'h02;
  localparam logic [7:0] MODE_VELOCITY = 8'h01;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] insn;
    logic [7:0] ctype;
    logic [7:0] bank;
    logic [31:0] value;
  } frame_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] status;
    logic [7:0] insn;
    logic [31:0] value;
  } reply_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [3:0] flags;
    logic [15:0] pc;
  } context_t;

  function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
    return 8'(a + b);
  endfunction
endpackage

// ---- design/irq_vector_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_vector_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData,
  output logic [DEPTH-1:0] defined
);
  logic [DW-1:0] mem [DEPTH];
  logic [DEPTH-1:0] definedReg;

  assign defined = definedReg;

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      definedReg <= '0;
    end
    else if (wrEn)
    begin
      definedReg[wrAddr] <= 1'b1;
    end
  end
endmodule // irq_vector_mem
`default_nettype wire

// ---- design/motion_cmd_interrupt_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module motion_cmd_interrupt_engine #(
  parameter logic [7:0] MODULE_ADDR = 8'h01
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic rxReady,
  output motion_cmd_pkg::reply_t reply,
  output logic replyValid,
  input wire logic replyReady,
  input wire motion_cmd_pkg::frame_t progInsn,
  input wire logic progValid,
  output logic [15:0] progPc,
  output logic progAdvance,
  input wire logic [15:0] progNextPc,
  input wire logic [31:0] progAccu,
  input wire logic [31:0] progXreg,
  input wire logic [3:0] progFlags,
  output motion_cmd_pkg::context_t restoreCtx,
  output logic restoreValid,
  input wire logic [motion_cmd_pkg::NUM_SRC-1:0] irqEvent,
  output logic [31:0] targetVelocity,
  output logic [7:0] motionMode,
  output logic [7:0] velParamIndex,
  output logic [31:0] irqParam [motion_cmd_pkg::NUM_SRC],
  output logic inHandler
);
  import motion_cmd_pkg::*;

  // ----------------------------------------
  // frame assembly
  // ----------------------------------------
  logic [3:0] byteCnt_reg;
  logic [63:0] shift_reg;
  logic [7:0] sum_reg;
  logic frameDone_reg;
  logic sumOk_reg;
  wire logic lastByte = rxValid && rxReady && (byteCnt_reg == 4'(FRAME_LEN - 1));

  assign rxReady = !replyValid;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      byteCnt_reg <= '0;
      shift_reg <= '0;
      sum_reg <= '0;
      frameDone_reg <= 1'b0;
      sumOk_reg <= 1'b0;
    end
    else
    begin
      frameDone_reg <= lastByte;
      if (rxValid && rxReady)
      begin
        if (lastByte)
        begin
          byteCnt_reg <= '0;
          sum_reg <= '0;
          sumOk_reg <= (rxByte == sum_reg);
        end
        else
        begin
          byteCnt_reg <= byteCnt_reg + 4'h1;
          shift_reg <= {shift_reg[55:0], rxByte};
          sum_reg <= sum8(sum_reg, rxByte);
        end
      end
    end
  end

  wire frame_t hostFrame = frame_t'(shift_reg);
  wire logic hostCmd = frameDone_reg && (hostFrame.addr == MODULE_ADDR);

  // ----------------------------------------
  // instruction decode (shared by host and program)
  // ----------------------------------------
  wire frame_t cmd = hostCmd ? hostFrame : progInsn;
  wire logic progStep = !hostCmd && progValid;
  wire logic cmdAct = (hostCmd && sumOk_reg) || progStep;
  wire logic isRot = (cmd.insn == INSN_ROTATE_CW) || (cmd.insn == INSN_ROTATE_CCW);
  wire logic isStop = (cmd.insn == INSN_SOFT_STOP);
  wire logic isMotion = (isRot || isStop) && (cmd.ctype == 8'h00) && (cmd.bank == 8'h00);
  wire logic isParam = (cmd.insn == INSN_GLOBAL_PARAM) && (cmd.bank == IRQ_BANK);
  wire logic isEnable = (cmd.insn == INSN_IRQ_ENABLE) || (cmd.insn == INSN_IRQ_DISABLE);
  wire logic isVector = (cmd.insn == INSN_IRQ_VECTOR);
  wire logic isReturn = (cmd.insn == INSN_RETURN_IRQ) && progStep;
  wire logic known = isMotion || isParam || isEnable || isVector || isReturn;

  function automatic logic [1:0] srcIndex(input logic [7:0] num);
    if (num == IRQ_INPUT_CHANGE)
    begin
      return 2'd3;
    end
    return num[1:0];
  endfunction

  wire logic srcValid = (cmd.ctype <= IRQ_TIMER2) || (cmd.ctype == IRQ_INPUT_CHANGE);
  wire logic [1:0] srcSel = srcIndex(cmd.ctype);

  // ----------------------------------------
  // motion target
  // ----------------------------------------
  logic [31:0] vel_reg;
  logic [7:0] mode_reg;
  wire logic [31:0] vel_next = (cmd.insn == INSN_ROTATE_CW) ? cmd.value
                             : (cmd.insn == INSN_ROTATE_CCW) ? 32'(-$signed(cmd.value))
                             : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vel_reg <= '0;
      mode_reg <= '0;
    end
    else if (cmdAct && isMotion)
    begin
      vel_reg <= vel_next;
      mode_reg <= MODE_VELOCITY;
    end
  end

  assign targetVelocity = vel_reg;
  assign motionMode = mode_reg;
  assign velParamIndex = TARGET_VEL_PARAM;

  // ----------------------------------------
  // interrupt configuration
  // ----------------------------------------
  logic [NUM_SRC-1:0] enable_reg;
  logic globalEn_reg;
  logic [31:0] param_reg [NUM_SRC];
  logic [NUM_SRC-1:0] vecDefined;
  logic [15:0] vecAddr;
  logic [NUM_SRC-1:0] pending_reg;
  logic [1:0] takeSrc;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enable_reg <= '0;
      globalEn_reg <= 1'b0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
        param_reg[i] <= '0;
      end
    end
    else if (cmdAct && isEnable)
    begin
      if (cmd.ctype == IRQ_GLOBAL)
      begin
        globalEn_reg <= (cmd.insn == INSN_IRQ_ENABLE);
      end
      else if (srcValid)
      begin
        enable_reg[srcSel] <= (cmd.insn == INSN_IRQ_ENABLE);
      end
    end
    else if (cmdAct && isParam && srcValid)
    begin
      param_reg[srcSel] <= cmd.value;
    end
  end

  assign irqParam = param_reg;

  irq_vector_mem #(
    .DEPTH(NUM_SRC),
    .AW(2),
    .DW(16)
  ) vectors (
    .clk(clk),
    .rst(rst),
    .wrEn(cmdAct && isVector && srcValid),
    .wrAddr(srcSel),
    .wrData(cmd.value[15:0]),
    .rdAddr(takeSrc),
    .rdData(vecAddr),
    .defined(vecDefined)
  );

  // ----------------------------------------
  // interrupt dispatch
  // ----------------------------------------
  typedef enum logic [1:0] {RUN, FETCH, HANDLER} irq_state_t;
  irq_state_t state_reg;
  context_t saved_reg;
  logic [15:0] pc_reg;
  logic restore_reg;

  wire logic [NUM_SRC-1:0] ready = pending_reg & enable_reg & vecDefined;
  wire logic anyReady = (|ready) && globalEn_reg;
  wire logic boundary = progStep && (state_reg == RUN);
  wire logic take = anyReady && boundary;

  always_comb
  begin
    takeSrc = 2'd0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (ready[i])
      begin
        takeSrc = 2'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pending_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (irqEvent[i])
        begin
          pending_reg[i] <= 1'b1;
        end
        else if (take && (takeSrc == 2'(i)))
        begin
          pending_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= RUN;
      saved_reg <= '0;
      pc_reg <= '0;
      restore_reg <= 1'b0;
    end
    else
    begin
      restore_reg <= 1'b0;
      case (state_reg)
        RUN:
        begin
          if (take)
          begin
            saved_reg <= '{progAccu, progXreg, progFlags, pc_reg};
            state_reg <= FETCH;
          end
          else if (progStep)
          begin
            pc_reg <= progNextPc;
          end
        end
        FETCH:
        begin
          pc_reg <= vecAddr;
          state_reg <= HANDLER;
        end
        HANDLER:
        begin
          if (isReturn)
          begin
            pc_reg <= saved_reg.pc;
            restore_reg <= 1'b1;
            state_reg <= RUN;
          end
          else if (progStep)
          begin
            pc_reg <= progNextPc;
          end
        end
        default:
        begin
          state_reg <= RUN;
        end
      endcase
    end
  end

  assign progPc = pc_reg;
  assign progAdvance = progStep && (state_reg != FETCH) && !take;
  assign restoreCtx = saved_reg;
  assign restoreValid = restore_reg;
  assign inHandler = (state_reg != RUN);

  // ----------------------------------------
  // host reply
  // ----------------------------------------
  reply_t reply_reg;
  logic replyValid_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reply_reg <= '0;
      replyValid_reg <= 1'b0;
    end
    else if (hostCmd)
    begin
      replyValid_reg <= 1'b1;
      reply_reg.addr <= MODULE_ADDR;
      reply_reg.insn <= hostFrame.insn;
      reply_reg.value <= '0;
      reply_reg.status <= !sumOk_reg ? STATUS_BAD_SUM
                        : known ? STATUS_OK : STATUS_BAD_CMD;
    end
    else if (replyReady)
    begin
      replyValid_reg <= 1'b0;
    end
  end

  assign reply = reply_reg;
  assign replyValid = replyValid_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_take;
    take;
  endsequence

  sequence s_enter;
    (state_reg == FETCH) ##1 (state_reg == HANDLER);
  endsequence

  a_take_vector: assert property (@(posedge clk) disable iff (rst)
    s_take |=> s_enter) else $error("handler not entered");
  a_save_ctx: assert property (@(posedge clk) disable iff (rst)
    take |=> saved_reg.accu == $past(progAccu) && saved_reg.xreg == $past(progXreg)
      && saved_reg.flags == $past(progFlags)) else $error("context not saved");
  a_no_nest: assert property (@(posedge clk) disable iff (rst)
    (state_reg == HANDLER) && !isReturn |=> (state_reg == HANDLER) && $stable(saved_reg))
    else $error("nested interrupt");
  a_restore_ctx: assert property (@(posedge clk) disable iff (rst)
    restoreValid |-> progPc == saved_reg.pc && state_reg == RUN) else $error("bad resume");
  a_global_gate: assert property (@(posedge clk) disable iff (rst)
    take |-> globalEn_reg && enable_reg[takeSrc]) else $error("take without enables");
  a_cw_vel: assert property (@(posedge clk) disable iff (rst)
    cmdAct && isMotion && cmd.insn == INSN_ROTATE_CW |=> targetVelocity == $past(cmd.value)
      && motionMode == MODE_VELOCITY) else $error("rotate cw wrong");
  a_stop_zero: assert property (@(posedge clk) disable iff (rst)
    cmdAct && isMotion && isStop |=> targetVelocity == 32'h0000_0000) else $error("stop wrong");
  a_reply_ok: assert property (@(posedge clk) disable iff (rst)
    hostCmd && sumOk_reg && isMotion |=> replyValid && reply.status == STATUS_OK)
    else $error("reply status wrong");
  a_bad_sum: assert property (@(posedge clk) disable iff (rst)
    hostCmd && !sumOk_reg |=> $stable(targetVelocity) && reply.status == STATUS_BAD_SUM)
    else $error("bad checksum accepted");
  a_boundary: assert property (@(posedge clk) disable iff (rst)
    !progValid && (state_reg == RUN) |=> (state_reg == RUN)) else $error("interrupt mid instruction");
endmodule // motion_cmd_interrupt_engine
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic rxReady,
  input wire motion_cmd_pkg::reply_t reply,
  input wire logic replyValid,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic replyReady
);
  import motion_cmd_pkg::*;
  // ----------------------------------------
  // frame sender and reply taker
  // ----------------------------------------
  initial
  begin
    rxByte = 8'h5A;
    rxValid = 1'b0;
    replyReady = 1'b0;
  end

  task automatic xfer(input frame_t f, input logic [7:0] adj, input int slow,
                      output reply_t r, output logic got);
    logic [7:0] b [FRAME_LEN];
    logic ok;
    int i;
    b[8] = 8'h00;
    for (i = 0; i < 8; i++)
    begin
      b[i] = f[63-8*i -: 8];
      b[8] = 8'(b[8] + b[i]);
    end
    b[8] = 8'(b[8] + adj);
    for (i = 0; i < FRAME_LEN; i++)
    begin
      rxByte = b[i];
      rxValid = 1'b1;
      do
      begin
        #2;
        ok = rxReady;
        @(posedge clk);
        #1;
      end while (ok !== 1'b1);
    end
    rxValid = 1'b0;
    rxByte = ~b[8];
    got = 1'b0;
    r = '0;
    for (i = 0; i < 12 && !got; i++)
    begin
      @(posedge clk);
      #1;
      got = (replyValid === 1'b1);
    end
    if (got)
    begin
      repeat (slow)
      begin
        @(posedge clk);
        #1;
      end
      r = reply;
      replyReady = 1'b1;
      @(posedge clk);
      #1;
      replyReady = 1'b0;
    end
  endtask
endmodule // host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import motion_cmd_pkg::*;
  logic clk = 1'b0;
  logic rst;
  logic [7:0] rxByte;
  logic rxValid, rxReady, replyValid, replyReady, progValid, progAdvance;
  logic restoreValid, inHandler, got, sawRestore, advSeen;
  reply_t reply, rep;
  frame_t progInsn;
  logic [15:0] progPc, progNextPc;
  logic [31:0] progAccu, progXreg, targetVelocity;
  logic [3:0] progFlags;
  context_t restoreCtx, ctxSeen;
  logic [NUM_SRC-1:0] irqEvent;
  logic [7:0] motionMode, velParamIndex;
  logic [31:0] irqParam [NUM_SRC];
  int errors = 0;
  int tests_run = 0;

  always #2 clk = ~clk;

  motion_cmd_interrupt_engine uut (.clk(clk), .rst(rst), .rxByte(rxByte),
    .rxValid(rxValid), .rxReady(rxReady), .reply(reply), .replyValid(replyValid),
    .replyReady(replyReady), .progInsn(progInsn), .progValid(progValid),
    .progPc(progPc), .progAdvance(progAdvance), .progNextPc(progNextPc),
    .progAccu(progAccu), .progXreg(progXreg), .progFlags(progFlags),
    .restoreCtx(restoreCtx), .restoreValid(restoreValid), .irqEvent(irqEvent),
    .targetVelocity(targetVelocity), .motionMode(motionMode),
    .velParamIndex(velParamIndex), .irqParam(irqParam), .inHandler(inHandler));

  host_model host (.clk(clk), .rxReady(rxReady), .reply(reply),
    .replyValid(replyValid), .rxByte(rxByte), .rxValid(rxValid),
    .replyReady(replyReady));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] a, i, t, b, input logic [31:0] v,
                     input logic [7:0] adj, input int slow);
    host.xfer(frame_t'{a, i, t, b, v}, adj, slow, rep, got);
  endtask

  task automatic step(input logic [7:0] i, input logic [15:0] nxt);
    int n;
    progInsn = frame_t'{8'h01, i, 8'h00, 8'h00, 32'h00000000};
    progNextPc = nxt;
    progValid = 1'b1;
    #2;
    advSeen = progAdvance;
    @(posedge clk);
    #1;
    progValid = 1'b0;
    sawRestore = 1'b0;
    for (n = 0; n < 5; n++)
    begin
      if (restoreValid === 1'b1)
        ctxSeen = restoreCtx;
      sawRestore = sawRestore | (restoreValid === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask

  task automatic fire(input int k);
    irqEvent[k] = 1'b1;
    @(posedge clk);
    #1;
    irqEvent = '0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_motion();
    logic [7:0] ins [4] = '{INSN_ROTATE_CW, INSN_ROTATE_CCW, INSN_ROTATE_CW, INSN_SOFT_STOP};
    logic [31:0] val [4] = '{32'h0000C800, 32'h0000C800, 32'h80000000, 32'h00000000};
    logic [31:0] vel [4] = '{32'h0000C800, 32'hFFFF3800, 32'h80000000, 32'h00000000};
    int i;
    for (i = 0; i < 4; i++)
    begin
      cmd(8'h01, ins[i], 8'h00, 8'h00, val[i], 8'h00, i);
      check("status", rep.status, STATUS_OK);
      check("replyAddr", rep.addr, 8'h01);
      check("replyInsn", rep.insn, ins[i]);
      check("replyValue", rep.value, 32'h00000000);
      check("velocity", targetVelocity, vel[i]);
      check("mode", motionMode, MODE_VELOCITY);
      check("param", velParamIndex, TARGET_VEL_PARAM);
    end
    $display("done t_motion");
  endtask

  task automatic t_refuse();
    cmd(8'h01, INSN_ROTATE_CW, 8'h00, 8'h00, 32'h000004D2, 8'h01, 0);
    check("badSum", rep.status, STATUS_BAD_SUM);
    check("velKept", targetVelocity, 32'h00000000);
    cmd(8'h01, 8'h7F, 8'h00, 8'h00, 32'h00000000, 8'h00, 0);
    check("badCmd", rep.status, STATUS_BAD_CMD);
    cmd(8'h02, INSN_ROTATE_CW, 8'h00, 8'h00, 32'h000004D2, 8'h00, 0);
    check("otherAddr", got, 1'b0);
    check("velKept2", targetVelocity, 32'h00000000);
    $display("done t_refuse");
  endtask

  task automatic t_irq();
    cmd(8'h01, INSN_IRQ_VECTOR, IRQ_TIMER0, 8'h00, 32'h00000040, 8'h00, 0);
    cmd(8'h01, INSN_IRQ_VECTOR, IRQ_INPUT_CHANGE, 8'h00, 32'h00000060, 8'h00, 0);
    cmd(8'h01, INSN_GLOBAL_PARAM, IRQ_TIMER0, IRQ_BANK, 32'h000003E8, 8'h00, 0);
    check("irqParam", irqParam[0], 32'h000003E8);
    cmd(8'h01, INSN_IRQ_ENABLE, IRQ_TIMER0, 8'h00, 32'h00000000, 8'h00, 0);
    cmd(8'h01, INSN_IRQ_ENABLE, IRQ_INPUT_CHANGE, 8'h00, 32'h00000000, 8'h00, 0);
    fire(0);
    repeat (4) @(posedge clk);
    #1;
    check("noStep", inHandler, 1'b0);
    step(INSN_SOFT_STOP, 16'h0010);
    check("noGlobal", inHandler, 1'b0);
    check("pcNoGlobal", progPc, 16'h0010);
    check("advance", advSeen, 1'b1);
    cmd(8'h01, INSN_IRQ_ENABLE, IRQ_GLOBAL, 8'h00, 32'h00000000, 8'h00, 0);
    progAccu = 32'hA5A5A5A5;
    progXreg = 32'h3C3C3C3C;
    progFlags = 4'hA;
    step(INSN_SOFT_STOP, 16'h0011);
    check("entered", inHandler, 1'b1);
    check("vector", progPc, 16'h0040);
    check("held", advSeen, 1'b0);
    fire(3);
    step(INSN_SOFT_STOP, 16'h0041);
    check("noNest", progPc, 16'h0041);
    check("nestStep", inHandler, 1'b1);
    progAccu = 32'h00000000;
    progXreg = 32'h00000000;
    progFlags = 4'h0;
    step(INSN_RETURN_IRQ, 16'h0042);
    check("restore", sawRestore, 1'b1);
    check("accu", ctxSeen.accu, 32'hA5A5A5A5);
    check("xreg", ctxSeen.xreg, 32'h3C3C3C3C);
    check("flags", ctxSeen.flags, 4'hA);
    check("resumePc", progPc, 16'h0010);
    check("left", inHandler, 1'b0);
    step(INSN_SOFT_STOP, 16'h0011);
    check("deferred", progPc, 16'h0060);
    step(INSN_RETURN_IRQ, 16'h0061);
    cmd(8'h01, INSN_IRQ_DISABLE, IRQ_TIMER0, 8'h00, 32'h00000000, 8'h00, 0);
    fire(0);
    step(INSN_SOFT_STOP, 16'h0012);
    check("disabled", inHandler, 1'b0);
    check("pcDisabled", progPc, 16'h0012);
    $display("done t_irq");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    progInsn = '0;
    progValid = 1'b0;
    progNextPc = 16'h0000;
    progAccu = 32'h00000000;
    progXreg = 32'h00000000;
    progFlags = 4'h0;
    irqEvent = '0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_motion();
    t_refuse();
    t_irq();
    wrap_up();
  end

  initial
  begin
    #40000;
    errors++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
